// File: psm_pkg.sv
// psm_pkg: shared constants and types for the pin state controller
// assumes: single clock domain, nothing imported by users
package psm_pkg;

   // chip state as reported by the clock/reset unit
   typedef enum logic [2:0] {
      PSM_ST_POR    = 3'h0,  // power-on reset or low-voltage detect
      PSM_ST_XRST   = 3'h1,  // external reset input held low
      PSM_ST_IRST   = 3'h2,  // internal reset, external input high
      PSM_ST_RUN    = 3'h3,  // run or sleep
      PSM_ST_TIMER  = 3'h4,  // main timer, main oscillator still running
      PSM_ST_RTC    = 3'h5,
      PSM_ST_STOP   = 3'h6,
      PSM_ST_SUBTMR = 3'h7   // sub timer or low-speed CR timer (main osc stopped)
   } psm_state_e;

   // per-pin function selection
   typedef enum logic [2:0] {
      PSM_FN_GPIO   = 3'h0,
      PSM_FN_PERIPH = 3'h1,  // peripheral resource
      PSM_FN_EXTINT = 3'h2,  // external interrupt or nonmaskable input
      PSM_FN_SWD    = 3'h3,
      PSM_FN_ANALOG = 3'h4,
      PSM_FN_MOSC_O = 3'h5,  // main oscillator output side / ext main clock
      PSM_FN_SOSC_O = 3'h6,  // sub oscillator output side
      PSM_FN_SOSC_I = 3'h7   // sub oscillator input / external sub clock
   } psm_func_e;

   localparam int unsigned PSM_NPINS     = 8;
   localparam int unsigned PSM_FN_W      = 3;     // function code bits per pin
   localparam logic        PSM_LOW       = 1'b0;
   localparam logic        PSM_LEVEL_RST = 1'b0;

endpackage

// File: psm_hold_mem.sv
// psm_hold_mem: holds the last port output value and drive enable of each pin
// assumes: clk/srst of the parent, captures only while the parent asks
`timescale 1ns/1ps
`default_nettype none
module psm_hold_mem (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          srst,
   // capture side
   input  wire logic                          cap_en,
   input  wire logic [psm_pkg::PSM_NPINS-1:0] cap_out,
   input  wire logic [psm_pkg::PSM_NPINS-1:0] cap_oe,
   // held values, registered
   output logic      [psm_pkg::PSM_NPINS-1:0] held_out_ff,
   output logic      [psm_pkg::PSM_NPINS-1:0] held_oe_ff
);

   // capture while running so the value just before a mode change is kept
   always_ff @(posedge clk) begin
      if (srst) begin
         held_out_ff <= '0;
         held_oe_ff  <= '0;
      end else if (cap_en) begin
         held_out_ff <= cap_out;
         held_oe_ff  <= cap_oe;
      end
   end

endmodule
`default_nettype wire

// File: psm_pin_ctrl.sv
// psm_pin_ctrl: selects each pin's drive and input condition from chip state
// assumes: state from the clock/reset unit on clk; pin levels are synchronised in this module
// How it works
// - during power-on or low-voltage reset gpio settings are ignored and resource pins float.
// - during internal reset gpio settings are ignored, resource pins float with input on, reset pin keeps pull-up.
// - in run or sleep each pin except analog and sub oscillator input pins keeps its prior state, following its peripheral if one drives it.
// - in timer, rtc or stop a gpio keeps its state when the level bit is 0, else floats with input forced 0.
// - an external or nonmaskable interrupt pin keeps its prior state in every standby mode.
// - a debug pin has pull-up and input on during external or internal reset and keeps its state in run and standby.
// - an analog pin floats with digital input forced 0 and analog path on from external reset onward.
// - the main oscillator output pin keeps its state but floats with input 0 once oscillation stops, and in timer mode when the level bit is 1.
// - the sub oscillator output pin floats with input 0 in stop mode and in every reset state.
// - a sub oscillator input pin keeps its input enabled in every state.
// - an external main clock pin ignores settings in reset, keeps state, floats when the level bit is 1 or in rtc, stop or sub timer mode.
// - the standby level setting is one software-written control bit.
// - keeping state means a running peripheral is followed and a port holds its last output.
`timescale 1ns/1ps
`default_nettype none
module psm_pin_ctrl (
   // clock and reset
   input  wire logic                              clk,
   input  wire logic                              srst,
   // chip state and standby control
   input  wire psm_pkg::psm_state_e               chip_state,
   input  wire logic                              level_wr,
   input  wire logic                              level_wdata,
   output logic                                   standby_pin_level_ff,
   // per-pin configuration, 3 bits of function each
   input  wire logic [3*psm_pkg::PSM_NPINS-1:0]   pin_func,
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     periph_active,
   // requested drive from port and peripheral
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     port_out,
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     port_oe,
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     periph_out,
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     periph_oe,
   // pins
   input  wire logic [psm_pkg::PSM_NPINS-1:0]     pin_in,
   output logic      [psm_pkg::PSM_NPINS-1:0]     pin_out_ff,
   output logic      [psm_pkg::PSM_NPINS-1:0]     pin_oe_ff,
   output logic      [psm_pkg::PSM_NPINS-1:0]     pin_pullup_ff,
   output logic      [psm_pkg::PSM_NPINS-1:0]     analog_en_ff,
   // internal input seen by logic
   output logic      [psm_pkg::PSM_NPINS-1:0]     int_in_ff,
   // external reset pin
   input  wire logic                              external_reset_input_n,
   output logic                                   rst_pin_pullup_ff,
   output logic                                   rst_pin_in_ff
);

   logic [psm_pkg::PSM_NPINS-1:0] in_meta_ff;
   logic [psm_pkg::PSM_NPINS-1:0] in_sync_ff;
   logic                          xrst_meta_ff;
   logic                          xrst_sync_ff;
   logic [psm_pkg::PSM_NPINS-1:0] held_out_ff;
   logic [psm_pkg::PSM_NPINS-1:0] held_oe_ff;
   logic [psm_pkg::PSM_NPINS-1:0] nxt_out;
   logic [psm_pkg::PSM_NPINS-1:0] nxt_oe;
   logic [psm_pkg::PSM_NPINS-1:0] nxt_pu;
   logic [psm_pkg::PSM_NPINS-1:0] nxt_an;
   logic [psm_pkg::PSM_NPINS-1:0] nxt_ien;
   logic                          is_run;

   function automatic logic is_standby(input psm_pkg::psm_state_e s);
      return (s == psm_pkg::PSM_ST_TIMER) || (s == psm_pkg::PSM_ST_RTC) ||
             (s == psm_pkg::PSM_ST_STOP)  || (s == psm_pkg::PSM_ST_SUBTMR);
   endfunction

   function automatic logic is_reset(input psm_pkg::psm_state_e s);
      return (s == psm_pkg::PSM_ST_POR) || (s == psm_pkg::PSM_ST_XRST) ||
             (s == psm_pkg::PSM_ST_IRST);
   endfunction

   // two-stage synchronisers; first stage read only by the second
   always_ff @(posedge clk) begin
      if (srst) begin
         in_meta_ff   <= '0;
         in_sync_ff   <= '0;
         xrst_meta_ff <= 1'b1;
         xrst_sync_ff <= 1'b1;
      end else begin
         in_meta_ff   <= pin_in;
         in_sync_ff   <= in_meta_ff;
         xrst_meta_ff <= external_reset_input_n;
         xrst_sync_ff <= xrst_meta_ff;
      end
   end

   // standby level bit, software written
   always_ff @(posedge clk) begin
      if (srst)
         standby_pin_level_ff <= psm_pkg::PSM_LEVEL_RST;
      else if (level_wr)
         standby_pin_level_ff <= level_wdata;
   end

   assign is_run = (chip_state == psm_pkg::PSM_ST_RUN);

   // prior state is sampled only while running, so standby holds it
   psm_hold_mem u_hold (
      .clk         (clk),
      .srst        (srst),
      .cap_en      (is_run),
      .cap_out     (port_out),
      .cap_oe      (port_oe),
      .held_out_ff (held_out_ff),
      .held_oe_ff  (held_oe_ff)
   );

   // per-pin selection; defaults float with input forced low
   always_comb begin
      for (int i = 0; i < psm_pkg::PSM_NPINS; i++) begin
         logic                keep;
         logic                kout;
         logic                koe;
         psm_pkg::psm_func_e  fn;
         keep = 1'b0;
         kout = 1'b0;
         koe  = 1'b0;
         fn   = psm_pkg::psm_func_e'(pin_func[psm_pkg::PSM_FN_W*i +: psm_pkg::PSM_FN_W]);
         nxt_out[i] = psm_pkg::PSM_LOW;
         nxt_oe[i]  = 1'b0;
         nxt_pu[i]  = 1'b0;
         nxt_an[i]  = 1'b0;
         nxt_ien[i] = 1'b0;
         // prior state: peripheral followed if running, else port value
         if (periph_active[i]) begin
            kout = periph_out[i];
            koe  = periph_oe[i];
         end else if (is_run) begin
            kout = port_out[i];
            koe  = port_oe[i];
         end else begin
            kout = held_out_ff[i];
            koe  = held_oe_ff[i];
         end
         case (fn)
            psm_pkg::PSM_FN_GPIO, psm_pkg::PSM_FN_PERIPH: begin
               if (is_run)
                  keep = 1'b1;
               else if (is_standby(chip_state))
                  keep = !standby_pin_level_ff;
               else if (chip_state != psm_pkg::PSM_ST_POR && fn == psm_pkg::PSM_FN_PERIPH)
                  nxt_ien[i] = 1'b1;
               // power-on: settings ignored, float
            end
            psm_pkg::PSM_FN_EXTINT: begin
               if (!is_reset(chip_state))
                  keep = 1'b1;
            end
            psm_pkg::PSM_FN_SWD: begin
               if (chip_state == psm_pkg::PSM_ST_XRST || chip_state == psm_pkg::PSM_ST_IRST) begin
                  nxt_pu[i]  = 1'b1;
                  nxt_ien[i] = 1'b1;
               end else if (chip_state != psm_pkg::PSM_ST_POR)
                  keep = 1'b1;
            end
            psm_pkg::PSM_FN_ANALOG: begin
               if (chip_state != psm_pkg::PSM_ST_POR)
                  nxt_an[i] = 1'b1;
            end
            psm_pkg::PSM_FN_MOSC_O: begin
               // stops with main osc; external clock variant floats on the level bit
               if (is_run)
                  keep = 1'b1;
               else if (is_standby(chip_state))
                  keep = !standby_pin_level_ff &&
                         (chip_state == psm_pkg::PSM_ST_TIMER);
            end
            psm_pkg::PSM_FN_SOSC_O: begin
               if (!is_reset(chip_state))
                  keep = (chip_state != psm_pkg::PSM_ST_STOP);
            end
            psm_pkg::PSM_FN_SOSC_I: begin
               nxt_ien[i] = 1'b1;
            end
            default: begin
               keep = 1'b0;
            end
         endcase
         if (keep) begin
            nxt_out[i] = kout;
            nxt_oe[i]  = koe;
            nxt_ien[i] = 1'b1;
         end
      end
   end

   // registered pin controls
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_out_ff    <= '0;
         pin_oe_ff     <= '0;
         pin_pullup_ff <= '0;
         analog_en_ff  <= '0;
         int_in_ff     <= '0;
      end else begin
         pin_out_ff    <= nxt_out;
         pin_oe_ff     <= nxt_oe;
         pin_pullup_ff <= nxt_pu;
         analog_en_ff  <= nxt_an;
         int_in_ff     <= nxt_ien & in_sync_ff;  // forced 0 when input is off
      end
   end

   // reset pin always pulled up with input active
   always_ff @(posedge clk) begin
      if (srst) begin
         rst_pin_pullup_ff <= 1'b1;
         rst_pin_in_ff     <= 1'b1;
      end else begin
         rst_pin_pullup_ff <= 1'b1;
         rst_pin_in_ff     <= xrst_sync_ff;
      end
   end

endmodule
`default_nettype wire

// File: psm_pin_ctrl_assertions.sv
// psm_pin_ctrl_assertions: port checks on the pin state controller
// assumes: bound to psm_pin_ctrl; pin 0 gpio, 2 irq, 3 analog, 4 main osc, 5 sub osc
`timescale 1ns/1ps
`default_nettype none
module psm_pin_ctrl_assertions (
   // watched ports
   input wire logic                clk,
   input wire logic                srst,
   input wire psm_pkg::psm_state_e chip_state,
   input wire logic                level_wr,
   input wire logic                level_wdata,
   input wire logic                standby_pin_level_ff,
   input wire logic [23:0]         pin_func,
   input wire logic [7:0]          periph_active,
   input wire logic [7:0]          port_oe,
   input wire logic [7:0]          pin_oe_ff,
   input wire logic [7:0]          pin_pullup_ff,
   input wire logic [7:0]          analog_en_ff
);
   logic rst, stby, gpio0, irq2, dbg1, nopor, an3, mosc_off, sosc_off;
   // decoded state; every code above run is a standby mode
   assign rst   = chip_state inside {psm_pkg::PSM_ST_XRST, psm_pkg::PSM_ST_IRST};
   assign stby  = chip_state > psm_pkg::PSM_ST_RUN;
   assign gpio0 = pin_func[2:0] == psm_pkg::PSM_FN_GPIO && !periph_active[0];
   assign irq2  = pin_func[8:6] == psm_pkg::PSM_FN_EXTINT && !periph_active[2];
   assign dbg1  = pin_func[5:3] == psm_pkg::PSM_FN_SWD;
   assign nopor = chip_state != psm_pkg::PSM_ST_POR;
   assign an3   = pin_func[11:9] == psm_pkg::PSM_FN_ANALOG;
   // oscillator pins in the modes where their oscillator is stopped
   assign mosc_off = stby && chip_state != psm_pkg::PSM_ST_TIMER && pin_func[14:12] == psm_pkg::PSM_FN_MOSC_O;
   assign sosc_off = chip_state == psm_pkg::PSM_ST_STOP && pin_func[17:15] == psm_pkg::PSM_FN_SOSC_O;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // last run cycle captures, then standby with the level bit set
   sequence s_run_then_hold;
      chip_state == psm_pkg::PSM_ST_RUN && irq2 ##1 stby && standby_pin_level_ff && irq2;
   endsequence
   chk_por_float: assert property (chip_state == psm_pkg::PSM_ST_POR |=> pin_oe_ff == '0)
      else $error("pin driven in power-on reset");
   chk_rst_float: assert property (rst |=> pin_oe_ff == '0)
      else $error("pin driven in reset");
   chk_gpio_float: assert property (stby && standby_pin_level_ff && gpio0 |=> !pin_oe_ff[0])
      else $error("gpio driven in standby with level bit set");
   chk_irq_hold: assert property (s_run_then_hold |=> pin_oe_ff[2] == $past(port_oe[2], 2))
      else $error("irq pin lost its state in standby");
   chk_debug_pullup: assert property (rst && dbg1 |=> pin_pullup_ff[1])
      else $error("debug pin not pulled up in reset");
   chk_analog_path: assert property (an3 && nopor |=> analog_en_ff[3] && !pin_oe_ff[3])
      else $error("analog pin not floating with path on");
   chk_mosc_stop: assert property (mosc_off |=> !pin_oe_ff[4])
      else $error("main osc pin driven with oscillator stopped");
   chk_sosc_stop: assert property (sosc_off |=> !pin_oe_ff[5])
      else $error("sub osc pin driven in stop");
   chk_level_write: assert property (level_wr |=> standby_pin_level_ff == $past(level_wdata))
      else $error("level bit write lost");
endmodule
`default_nettype wire

// File: psm_board.sv
// psm_board: board circuitry around the controller's pins
// assumes: one clock; released lines without pull-up carry no stable level
`timescale 1ns/1ps
`default_nettype none
module psm_board (
   // clock and pin lines
   input  wire logic       clk,
   input  wire logic [7:0] oe,
   input  wire logic [7:0] dout,
   input  wire logic [7:0] pu,
   output logic      [7:0] lvl
);
   logic tog = 1'b0;
   // released lines without pull-up toggle so a stale level can never read back as valid
   always @(posedge clk) tog <= ~tog;
   assign lvl = (oe & dout) | (~oe & (pu | {8{tog}}));
endmodule
`default_nettype wire

// File: testbench.sv
// testbench: runs the pin state controller through reset, run and standby states
// assumes: psm_pkg, design, checker and board model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                clk, srst, level_wr, level_wdata, external_reset_input_n;
   logic                standby_pin_level_ff, rst_pin_pullup_ff, rst_pin_in_ff;
   psm_pkg::psm_state_e chip_state;
   logic [23:0]         pin_func;
   logic [7:0]          periph_active, port_out, port_oe, periph_out, periph_oe, pin_in;
   logic [7:0]          pin_out_ff, pin_oe_ff, pin_pullup_ff, analog_en_ff, int_in_ff, expv;
   int                  errors, compares;
   // design and the board around its pins
   psm_pin_ctrl u_psm_pin_ctrl (.clk, .srst, .chip_state, .level_wr, .level_wdata, .standby_pin_level_ff,
      .pin_func, .periph_active, .port_out, .port_oe, .periph_out, .periph_oe, .pin_in, .pin_out_ff, .pin_oe_ff,
      .pin_pullup_ff, .analog_en_ff, .int_in_ff, .external_reset_input_n, .rst_pin_pullup_ff, .rst_pin_in_ff);
   psm_board u_psm_board (.clk, .oe(pin_oe_ff), .dout(pin_out_ff), .pu(pin_pullup_ff), .lvl(pin_in));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // entered at a falling edge, leaves at one
   task automatic go(input psm_pkg::psm_state_e s, input int n);
      chip_state = s;
      repeat (n) @(negedge clk);
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hang guard, roughly ten times the expected run
   initial begin
      repeat (1000) @(posedge clk);
      errors++;
      test_done();
   end
   // pins: 0 gpio, 1 debug, 2 irq, 3 analog, 4 main osc out, 5 sub osc out, 6 sub osc in, 7 peripheral
   initial begin
      srst = 1'b1;
      chip_state = psm_pkg::PSM_ST_POR;
      level_wr = 1'b0;
      level_wdata = 1'b0;
      pin_func = 24'h3F5898;
      periph_active = 8'h80;
      port_out = 8'hA5;
      port_oe = 8'hFF;
      periph_out = 8'h00;
      periph_oe = 8'h80;
      external_reset_input_n = 1'b1;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      // power-on, external and internal reset: settings ignored, pins float
      for (int i = 0; i < 3; i++) begin
         external_reset_input_n = i != 1;
         go(psm_pkg::psm_state_e'(i), 4);
         chk("reset oe", pin_oe_ff, 8'h00);
         chk("debug pullup", pin_pullup_ff & 8'h02, (i > 0) ? 8'h02 : 8'h00);
         chk("reset pin", {6'h00, rst_pin_pullup_ff, rst_pin_in_ff}, {6'h00, 1'b1, external_reset_input_n});
         // released lines toggle each cycle, so an enabled input must follow them
         expv = int_in_ff;
         @(negedge clk);
         chk("live inputs", int_in_ff & 8'hC0, ~expv & ((i > 0) ? 8'hC0 : 8'h40));
      end
      $display("reset states done");
      go(psm_pkg::PSM_ST_RUN, 2);
      chk("run oe", pin_oe_ff & 8'hBF, 8'hB7);
      chk("run out", pin_out_ff & 8'hB7, 8'h25);
      chk("analog path", analog_en_ff, 8'h08);
      $display("run state done");
      // every standby mode with both level settings; port request dropped on entry
      for (int s = 4; s < 8; s++) begin
         for (int v = 0; v < 2; v++) begin
            port_out = 8'hA5;
            port_oe = 8'hFF;
            go(psm_pkg::PSM_ST_RUN, 2);
            level_wr = 1'b1;
            level_wdata = v[0];
            @(negedge clk);
            level_wr = 1'b0;
            chk("level bit", {7'h00, standby_pin_level_ff}, {7'h00, v[0]});
            port_out = 8'h00;
            port_oe = 8'h00;
            go(psm_pkg::psm_state_e'(s), 5);
            expv = {2'h0, s != 6, s == 4 && v == 0, 3'h3, v == 0};
            chk("standby oe", pin_oe_ff & 8'h3F, expv);
            chk("standby out", pin_out_ff & 8'h04, 8'h04);
            chk("standby in", int_in_ff & 8'h0D, v ? 8'h04 : 8'h05);
         end
      end
      $display("standby states done");
      test_done();
   end
endmodule
bind psm_pin_ctrl psm_pin_ctrl_assertions u_psm_pin_ctrl_assertions (.clk, .srst, .chip_state, .level_wr,
   .level_wdata, .standby_pin_level_ff, .pin_func, .periph_active, .port_oe, .pin_oe_ff, .pin_pullup_ff,
   .analog_en_ff);
`default_nettype wire
